// ---- design/cap_cfg_defs.vh ----
// Constants for the processor capability register block.
`ifndef CAP_CFG_DEFS_VH
`define CAP_CFG_DEFS_VH
`define CAP_ADDR_W 4
`define CAP_OFS_CAPCFG 4'h0
`define CAP_OFS_STRAPS 4'h4
`define CAP_OFS_MODE 4'h8
`define CAP_BIT_MCU 17
`define CAP_BIT_EXCISA 16
`define CAP_BIT_ISA_HI 15
`define CAP_BIT_ISA_LO 14
`define CAP_BIT_TLREG 13
`define CAP_BIT_SP2 11
`define CAP_BIT_SP 10
`define CAP_BIT_TRACE 8
`define CAP_ISA_BASE_ONLY 2'h0
`define CAP_ISA_COMP_ONLY 2'h1
`define CAP_ISA_BOTH_BASE 2'h2
`define CAP_ISA_BOTH_COMP 2'h3
`define CAP_RST_WORD 32'h00000000
`define CAP_STRAP_WAIT 2'h3
`endif

// ---- design/strap_sync.v ----
// Two-flop synchroniser for the externally driven strap pins.
module strap_sync (
    // Clock and reset.
    input wire clk_i,
    input wire rst_i,
    // Asynchronous pins and their synchronised copy.
    input wire [2:0] async_i,
    output reg [2:0] sync_o
);
    reg [2:0] meta_q;

    // Only the second stage is read by other logic.
    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= 3'h0;
            sync_o <= 3'h0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule

// ---- design/cap_cfg_regs.v ----
// Read-only processor capability register with a classic Wishbone slave.
//
// Behaviour
// - Bit 17 reads 1 when the microcontroller extension exists, else 0.
// - Bit 16 gives exception vector instruction set, preset from an external pin.
// - Bits 15:14 give set availability from external pins; 0 base, 1 compressed.
// - Codes 2 and 3 have both sets; reset leaves base or compressed set.
// - Bit 13 reads 1 when the thread-local register exists.
// - Bit 11 reads 1 when signal-processing revision 2 exists.
// - Bit 10 reads 1 when the signal-processing extension exists.
// - Bit 8 reads 1 when the flow trace mechanism exists.
//
// The Wishbone register port and the register offsets are this design's own decisions.
`include "cap_cfg_defs.vh"
module cap_cfg_regs #(
    parameter [0:0] MCU_PRESENT = 1'b1,
    parameter [0:0] THREAD_LOCAL_PRESENT = 1'b1,
    parameter [0:0] SIGPROC_REV2_PRESENT = 1'b0,
    parameter [0:0] SIGPROC_PRESENT = 1'b1,
    parameter [0:0] FLOW_TRACE_PRESENT = 1'b0
) (
    // Clock and reset.
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave.
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [3:0] sel_i,
    input wire [`CAP_ADDR_W-1:0] adr_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // External strap pins.
    input wire exception_isa_select_i,
    input wire [1:0] instr_set_availability_i,
    // Decoded state towards the core.
    output reg exception_isa_select_o,
    output reg [1:0] instr_set_availability_o,
    output reg reset_isa_compressed_o
);
    wire [2:0] pins_s;
    reg exc_isa_q;
    reg [1:0] isa_q;
    reg latched_q;
    reg mode_q;
    reg [31:0] rd_d;

    strap_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({exception_isa_select_i, instr_set_availability_i}),
        .sync_o(pins_s)
    );

    // Straps are caught once after reset release; later pin motion is ignored.
    // The wait of a few cycles lets the synchroniser fill with real pin values.
    reg [1:0] wait_q;
    always @(posedge clk_i) begin
        if (rst_i) begin
            wait_q <= 2'h0;
            latched_q <= 1'b0;
            exc_isa_q <= 1'b0;
            isa_q <= `CAP_ISA_BASE_ONLY;
        end else if (!latched_q) begin
            wait_q <= wait_q + 2'h1;
            if (wait_q == `CAP_STRAP_WAIT) begin
                latched_q <= 1'b1;
                exc_isa_q <= pins_s[2];
                isa_q <= pins_s[1:0];
            end
        end
    end

    // Set that the core runs after reset, from the availability code.
    always @(posedge clk_i) begin
        if (rst_i) begin
            mode_q <= 1'b0;
        end else begin
            case (isa_q)
                `CAP_ISA_BASE_ONLY: mode_q <= 1'b0;
                `CAP_ISA_COMP_ONLY: mode_q <= 1'b1;
                `CAP_ISA_BOTH_BASE: mode_q <= 1'b0;
                default: mode_q <= 1'b1;
            endcase
        end
    end

    // Capability word; reserved bits read zero.
    always @* begin
        rd_d = `CAP_RST_WORD;
        case (adr_i)
            `CAP_OFS_CAPCFG: begin
                rd_d[`CAP_BIT_MCU] = MCU_PRESENT;
                rd_d[`CAP_BIT_EXCISA] = exc_isa_q;
                rd_d[`CAP_BIT_ISA_HI:`CAP_BIT_ISA_LO] = isa_q;
                rd_d[`CAP_BIT_TLREG] = THREAD_LOCAL_PRESENT;
                rd_d[`CAP_BIT_SP2] = SIGPROC_REV2_PRESENT;
                rd_d[`CAP_BIT_SP] = SIGPROC_PRESENT;
                rd_d[`CAP_BIT_TRACE] = FLOW_TRACE_PRESENT;
            end
            `CAP_OFS_STRAPS: rd_d[0] = latched_q;
            `CAP_OFS_MODE: rd_d[0] = mode_q;
            default: rd_d = `CAP_RST_WORD;
        endcase
    end

    // Single-cycle ack; writes are accepted and discarded so nothing changes.
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= cyc_i & stb_i & ~ack_o;
            dat_o <= (cyc_i & stb_i & ~we_i) ? rd_d : 32'h00000000;
        end
    end

    // Registered copies for the core.
    always @(posedge clk_i) begin
        if (rst_i) begin
            exception_isa_select_o <= 1'b0;
            instr_set_availability_o <= 2'h0;
            reset_isa_compressed_o <= 1'b0;
        end else begin
            exception_isa_select_o <= exc_isa_q;
            instr_set_availability_o <= isa_q;
            reset_isa_compressed_o <= mode_q;
        end
    end
endmodule

// ---- testbench/cap_cfg_chk.sv ----
// Port checker for the capability register block.
module cap_cfg_chk (
    // Clock, reset and bus.
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [3:0] adr_i,
    input wire [31:0] dat_o,
    input wire ack_o,
    // Latched straps.
    input wire exception_isa_select_o,
    input wire [1:0] instr_set_availability_o,
    input wire reset_isa_compressed_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Reads of the capability word, and a bus request.
    wire rd0 = ack_o && !we_i && adr_i == 4'h0;
    sequence s_req; cyc_i && stb_i && !ack_o; endsequence
    property p_ack; s_req |=> ack_o; endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    property p_pulse; ack_o |=> !ack_o; endproperty
    a_pulse: assert property (p_pulse) else $error("long ack");
    property p_wr; ack_o && we_i |-> dat_o == 32'h0; endproperty
    a_wr: assert property (p_wr) else $error("write data");
    property p_mcu; rd0 |-> dat_o[17]; endproperty
    a_mcu: assert property (p_mcu) else $error("mcu bit");
    property p_exc; rd0 |-> dat_o[16] == exception_isa_select_o; endproperty
    a_exc: assert property (p_exc) else $error("exc bit");
    property p_isa; rd0 |-> dat_o[15:14] == instr_set_availability_o; endproperty
    a_isa: assert property (p_isa) else $error("isa code");
    property p_rs; ack_o && adr_i == 4'h8 |-> dat_o == {31'h0, reset_isa_compressed_o}; endproperty
    a_rs: assert property (p_rs) else $error("reset set");
    property p_flags; rd0 |-> dat_o[13:8] == 6'h24; endproperty
    a_flags: assert property (p_flags) else $error("flags");
endmodule
bind cap_cfg_regs cap_cfg_chk chk (.*);

// ---- testbench/cpu_capability_config_fields_test.sv ----
// Bus test of the capability register block.
module cpu_capability_config_fields_test;
    timeunit 1ns;
    timeprecision 1ns;
    reg clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ex = 0;
    reg [3:0] adr_i = 4'h0;
    reg [1:0] av = 2'h0;
    reg [31:0] d;
    wire [31:0] dat_o;
    wire ack_o, ex_o, rc_o;
    wire [1:0] av_o;
    integer bad_count = 0, n_tests = 0, c;
    cap_cfg_regs uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .sel_i(4'hf), .adr_i(adr_i), .dat_i(32'hffffffff), .dat_o(dat_o), .ack_o(ack_o),
        .exception_isa_select_i(ex), .instr_set_availability_i(av),
        .exception_isa_select_o(ex_o), .instr_set_availability_o(av_o),
        .reset_isa_compressed_o(rc_o));
    initial forever #25 clk_i = ~clk_i;
    // Report and end the run.
    task test_done; begin
        $display("checks %0d errors %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    end endtask
    task cmp(input [31:0] e, input [31:0] g); begin
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value word exp %h got %h", e, g);
        end
    end endtask
    // One classic cycle; the wait is bounded so a dead slave ends the run.
    task bus(input [3:0] a, input w); integer i; begin
        cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a;
        for (i = 0; i < 9 && ack_o !== 1'b1; i++) @(posedge clk_i);
        if (i == 9) begin bad_count++; test_done; end
        d = dat_o; cyc_i <= 0; stb_i <= 0; @(posedge clk_i);
    end endtask
    // Every strap code, each under its own reset.
    initial begin
        for (c = 0; c < 8; c++) begin
            ex <= c[2]; av <= c[1:0]; rst_i <= 1;
            repeat (20) @(posedge clk_i);
            rst_i <= 0;
            repeat (10) @(posedge clk_i);
            bus(4'h0, 1); bus(4'h0, 0); cmp({14'h0, 1'b1, c[2:0], 14'h2400}, d);
            bus(4'h4, 0); cmp(32'h1, d);
            bus(4'h8, 0); cmp({31'h0, c[0]}, d);
            bus(4'hc, 0); cmp(32'h0, d);
            cmp({28'h0, c[2:0], c[0]}, {28'h0, ex_o, av_o, rc_o});
            ex <= ~c[2]; av <= ~c[1:0];
            repeat (10) @(posedge clk_i);
            bus(4'h0, 0); cmp({14'h0, 1'b1, c[2:0], 14'h2400}, d);
        end
        test_done;
    end
endmodule
